// file: design/digipot_defs.svh
// Constants for the serial rheostat: frame layout, register values, memory map.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DIGIPOT_DEFS_SVH
`define DIGIPOT_DEFS_SVH

// ==========================================================================
// Frame layout
`define WORD_W 16
`define WORD_MSB 15
`define CMD_MSB 13
`define CMD_LSB 10
`define DATA_MSB 9
`define PAD_ZERO 6'h00

// ==========================================================================
// Wiper register
`define WIPER_W 10
`define TAP_COUNT 1024
`define MIDSCALE 10'h200

// ==========================================================================
// Control register bits and reset value
`define CTRL_W 3
`define CTRL_RESET 3'h0
`define CTRL_PROG_EN 0
`define CTRL_WRITE_EN 1
`define CTRL_PROG_OK 2

// ==========================================================================
// Nonvolatile memory map
`define ADDR_W 6
`define FUSE_DEPTH 50
`define FUSE_FIRST_ADDR 6'h01
`define TOL_SIGN_INTEGER_ADDR 6'h39
`define TOL_FRACTION_ADDR 6'h3a

// ==========================================================================
// Pin indices within the synchroniser vectors
`define PIN_COUNT 3
`define PIN_SCLK 0
`define PIN_DIN 1
`define PIN_SYNC_N 2
// Reset levels of the synchroniser stages match the idle pins, so no false edge follows reset.
`define PIN_IDLE 3'h6

`endif

// file: design/digipot_pkg.sv
// Types shared by the rheostat core and its nonvolatile store.
// Assumes no surroundings beyond a SystemVerilog compiler.
package digipot_pkg;

  // ==========================================================================
  // Commands, in their wire encoding order
  typedef enum logic [3:0] {
    CMD_NOP,
    CMD_WRITE_WIPER,
    CMD_READ_WIPER,
    CMD_STORE_FUSE,
    CMD_SOFT_RESET,
    CMD_READ_MEMORY,
    CMD_READ_LAST_ADDR,
    CMD_WRITE_CONTROL,
    CMD_READ_CONTROL
  } cmd_type;

  // ==========================================================================
  // Power-on preset sequence
  typedef enum logic [0:0] {
    PRESET_RESTORE,
    RUNNING
  } preset_state_type;

endpackage

// file: design/nvm_if.sv
// Link between the serial core and the fuse wiper memory.
// Assumes both ends run on the same clock.
`include "digipot_defs.svh"

interface nvm_if;
  logic prog_req;
  logic [`WIPER_W-1:0] prog_data;
  logic prog_ack;
  logic prog_pass;
  logic [`ADDR_W-1:0] rd_addr;
  logic [`WIPER_W-1:0] rd_data;
  logic last_valid;
  logic [`WIPER_W-1:0] last_data;
  logic [`ADDR_W-1:0] last_addr;

  modport core (output prog_req, output prog_data, output rd_addr, input prog_ack, input prog_pass,
                input rd_data, input last_valid, input last_data, input last_addr);
  modport mem (input prog_req, input prog_data, input rd_addr, output prog_ack, output prog_pass,
               output rd_data, output last_valid, output last_data, output last_addr);
endinterface

// file: design/fuse_wiper_memory.sv
// Nonvolatile store: one-time wiper locations and factory tolerance words.
// Assumes the core raises prog_req for one cycle per store command.
`include "digipot_defs.svh"

module fuse_wiper_memory
  import digipot_pkg::*;
#(
  parameter int DEPTH = `FUSE_DEPTH,
  parameter logic [`WIPER_W-1:0] TOL_SIGN_INTEGER = 10'h000,
  parameter logic [`WIPER_W-1:0] TOL_FRACTION = 10'h000
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  nvm_if.mem nv
);

  localparam logic [`ADDR_W-1:0] DEPTH_C = `ADDR_W'(DEPTH);

  logic [`WIPER_W-1:0] fuse_q [DEPTH];
  logic [`WIPER_W-1:0] fuse_d [DEPTH];
  logic [`ADDR_W-1:0] count_q, count_d;
  logic ack_q, ack_d;
  logic pass_q, pass_d;
  logic [`ADDR_W-1:0] rd_index;
  logic [`ADDR_W-1:0] last_index;

  // ==========================================================================
  // Programming: each store takes the next free location until all are used.
  always_comb begin
    fuse_d = fuse_q;
    count_d = count_q;
    ack_d = 1'b0;
    pass_d = 1'b0;
    if (nv.prog_req) begin
      ack_d = 1'b1;
      if (count_q < DEPTH_C) begin
        fuse_d[count_q] = nv.prog_data;
        count_d = count_q + `FUSE_FIRST_ADDR;
        pass_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        fuse_q[i] <= '0;
      end
      count_q <= '0;
      ack_q <= 1'b0;
      pass_q <= 1'b0;
    end else begin
      fuse_q <= fuse_d;
      count_q <= count_d;
      ack_q <= ack_d;
      pass_q <= pass_d;
    end
  end

  // ==========================================================================
  // Read side: location n holds the n-th programmed value.
  always_comb begin
    rd_index = nv.rd_addr - `FUSE_FIRST_ADDR;
    last_index = count_q - `FUSE_FIRST_ADDR;
    nv.rd_data = '0;
    if (nv.rd_addr == `TOL_SIGN_INTEGER_ADDR) begin
      nv.rd_data = TOL_SIGN_INTEGER;
    end else if (nv.rd_addr == `TOL_FRACTION_ADDR) begin
      nv.rd_data = TOL_FRACTION;
    end else if (nv.rd_addr >= `FUSE_FIRST_ADDR && nv.rd_addr <= count_q) begin
      nv.rd_data = fuse_q[rd_index];
    end
    nv.last_valid = (count_q != '0);
    nv.last_addr = count_q;
    nv.last_data = (count_q != '0) ? fuse_q[last_index] : `MIDSCALE;
  end

  assign nv.prog_ack = ack_q;
  assign nv.prog_pass = pass_q;

  // ==========================================================================
  // Checks
  property p_tol_high;
    @(posedge clk_i) disable iff (!resetn_i)
    nv.rd_addr == `TOL_SIGN_INTEGER_ADDR |-> nv.rd_data == TOL_SIGN_INTEGER;
  endproperty
  a_tol_high: assert property (p_tol_high) else $error("tolerance high word wrong");

  property p_tol_low;
    @(posedge clk_i) disable iff (!resetn_i)
    nv.rd_addr == `TOL_FRACTION_ADDR |-> nv.rd_data == TOL_FRACTION;
  endproperty
  a_tol_low: assert property (p_tol_low) else $error("tolerance low word wrong");

  property p_prog_store;
    @(posedge clk_i) disable iff (!resetn_i)
    nv.prog_req && count_q < DEPTH_C |=> nv.last_valid && nv.last_data == $past(nv.prog_data);
  endproperty
  a_prog_store: assert property (p_prog_store) else $error("stored value not latest");

endmodule

// file: design/digipot_serial_daisy_chain.sv
// Serial command port of a single-channel 1024-tap digital rheostat.
// Assumes SCLK_I, DIN_I and SYNC_N_I come from a host in another clock domain,
// and an external pull-up on the open-drain chain output.
//
// Notes on behaviour
// - The chain output changes only after a rising serial clock edge, a frame start, or a frame end (release).
// - The chain output only pulls low, releasing the line for a one and outside frames.
// - Read-wiper and memory-read commands put that value on the chain output in the next frame.
// - The 10-bit wiper code selects exactly one of 1024 taps.
// - Factory tolerance is a 16-bit sign-magnitude value in two read-only locations.
// - The tolerance high word holds the sign in bit 7 and the integer in bits 6 to 0.
// - The tolerance low word holds the fraction in bits 7 to 0.
// - After power-up the wiper is midscale and stays there, since the same reset empties the fuse store.
// - The soft reset command reloads the latest programmed value, or midscale if none.
`include "digipot_defs.svh"

module digipot_serial_daisy_chain
  import digipot_pkg::*;
#(
  parameter int FUSE_DEPTH = `FUSE_DEPTH,
  parameter logic [`WIPER_W-1:0] TOL_SIGN_INTEGER = 10'h000,
  parameter logic [`WIPER_W-1:0] TOL_FRACTION = 10'h000
) (
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire logic SCLK_I,
  input wire logic DIN_I,
  input wire logic SYNC_N_I,
  output logic CHAIN_DATA_OUT_O,
  output logic CHAIN_DATA_OE_N_O,
  output logic [`WIPER_W-1:0] WIPER_CODE_O,
  output logic [`TAP_COUNT-1:0] TAP_SELECT_O
);

  nvm_if nv ();

  logic [`PIN_COUNT-1:0] pin_meta_q, pin_meta_d;
  logic [`PIN_COUNT-1:0] pin_sync_q, pin_sync_d;
  logic [`PIN_COUNT-1:0] pin_prev_q, pin_prev_d;
  logic [`WORD_W-1:0] shift_q, shift_d;
  logic oe_n_q, oe_n_d;
  logic [`WIPER_W-1:0] wiper_q, wiper_d;
  logic [`TAP_COUNT-1:0] tap_q, tap_d;
  logic [`CTRL_W-1:0] ctrl_q, ctrl_d;
  preset_state_type state_q, state_d;
  logic sclk_rise, sclk_fall, frame_active, frame_start, frame_end, execute;
  logic [3:0] cmd;
  logic [`WIPER_W-1:0] cmd_data;

  function automatic logic [`WORD_W-1:0] readback_word(input logic [`WIPER_W-1:0] value);
    return {`PAD_ZERO, value};
  endfunction

  // ==========================================================================
  // Pin edge detection, from the second synchroniser stage and its one-cycle-delayed copy.
  assign sclk_rise = pin_sync_q[`PIN_SCLK] & ~pin_prev_q[`PIN_SCLK];
  assign sclk_fall = ~pin_sync_q[`PIN_SCLK] & pin_prev_q[`PIN_SCLK];
  assign frame_active = ~pin_sync_q[`PIN_SYNC_N];
  assign frame_start = ~pin_sync_q[`PIN_SYNC_N] & pin_prev_q[`PIN_SYNC_N];
  assign frame_end = pin_sync_q[`PIN_SYNC_N] & ~pin_prev_q[`PIN_SYNC_N];
  assign execute = frame_end && state_q == RUNNING;
  assign cmd = shift_q[`CMD_MSB:`CMD_LSB];
  assign cmd_data = shift_q[`DATA_MSB:0];

  assign nv.rd_addr = cmd_data[`ADDR_W-1:0];
  assign nv.prog_data = wiper_q;
  assign nv.prog_req = execute && cmd == CMD_STORE_FUSE && ctrl_q[`CTRL_PROG_EN];

  // ==========================================================================
  // Next-state logic for the whole port except the chain data output register.
  always_comb begin
    pin_meta_d = {SYNC_N_I, DIN_I, SCLK_I};
    pin_sync_d = pin_meta_q;
    pin_prev_d = pin_sync_q;
    shift_d = shift_q;
    oe_n_d = oe_n_q;
    wiper_d = wiper_q;
    ctrl_d = ctrl_q;
    state_d = state_q;

    // Frame shifting: sample on the falling edge, present on the rising edge.
    if (!frame_active) begin
      oe_n_d = 1'b1;
    end else if (frame_start || sclk_rise) begin
      oe_n_d = shift_q[`WORD_MSB];
    end
    if (frame_active && sclk_fall) begin
      shift_d = {shift_q[`WORD_MSB-1:0], pin_sync_q[`PIN_DIN]};
    end

    // Power-on preset: the reset value is midscale, kept because the same reset has emptied the fuse store.
    if (state_q == PRESET_RESTORE) begin
      if (nv.last_valid) begin
        wiper_d = nv.last_data;
      end
      state_d = RUNNING;
    end

    if (nv.prog_ack) begin
      ctrl_d[`CTRL_PROG_OK] = nv.prog_pass;
    end

    // Command execution; anything not read back stays in the shifter for the chain.
    if (execute) begin
      unique case (cmd)
        CMD_NOP: begin
        end
        CMD_WRITE_WIPER: begin
          if (ctrl_q[`CTRL_WRITE_EN]) begin
            wiper_d = cmd_data;
          end
        end
        CMD_READ_WIPER: begin
          shift_d = readback_word(wiper_q);
        end
        CMD_STORE_FUSE: begin
        end
        CMD_SOFT_RESET: begin
          wiper_d = nv.last_valid ? nv.last_data : `MIDSCALE;
        end
        CMD_READ_MEMORY: begin
          shift_d = readback_word(nv.rd_data);
        end
        CMD_READ_LAST_ADDR: begin
          shift_d = readback_word({4'h0, nv.last_addr});
        end
        CMD_WRITE_CONTROL: begin
          ctrl_d[`CTRL_PROG_EN] = cmd_data[`CTRL_PROG_EN];
          ctrl_d[`CTRL_WRITE_EN] = cmd_data[`CTRL_WRITE_EN];
        end
        CMD_READ_CONTROL: begin
          shift_d = readback_word({6'h00, ctrl_q[`CTRL_PROG_OK], 1'b0, ctrl_q[`CTRL_WRITE_EN],
                                   ctrl_q[`CTRL_PROG_EN]});
        end
        default: begin
        end
      endcase
    end

    tap_d = '0;
    tap_d[wiper_d] = 1'b1;
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pin_meta_q <= `PIN_IDLE;
      pin_sync_q <= `PIN_IDLE;
      pin_prev_q <= `PIN_IDLE;
      shift_q <= '0;
      oe_n_q <= 1'b1;
      wiper_q <= `MIDSCALE;
      tap_q <= `TAP_COUNT'(1) << `MIDSCALE;
      ctrl_q <= `CTRL_RESET;
      state_q <= PRESET_RESTORE;
    end else begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
      pin_prev_q <= pin_prev_d;
      shift_q <= shift_d;
      oe_n_q <= oe_n_d;
      wiper_q <= wiper_d;
      tap_q <= tap_d;
      ctrl_q <= ctrl_d;
      state_q <= state_d;
    end
  end

  // The pin is only ever driven low; its enable carries the data.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CHAIN_DATA_OUT_O <= 1'b0;
    end else begin
      CHAIN_DATA_OUT_O <= 1'b0;
    end
  end

  assign CHAIN_DATA_OE_N_O = oe_n_q;
  assign WIPER_CODE_O = wiper_q;
  assign TAP_SELECT_O = tap_q;

  // ==========================================================================
  // Nonvolatile store
  fuse_wiper_memory #(
    .DEPTH(FUSE_DEPTH),
    .TOL_SIGN_INTEGER(TOL_SIGN_INTEGER),
    .TOL_FRACTION(TOL_FRACTION)
  ) u_fuse_wiper_memory (
    .clk_i(SYS_CLK_I),
    .resetn_i(RESETN_I),
    .nv(nv.mem)
  );

  // ==========================================================================
  // Checks
  property p_out_edge;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
    $changed(CHAIN_DATA_OE_N_O) |-> $past(sclk_rise || frame_start || !frame_active);
  endproperty
  a_out_edge: assert property (p_out_edge) else $error("chain output moved off a rising edge");

  property p_release_idle;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
    !frame_active |=> CHAIN_DATA_OE_N_O && !CHAIN_DATA_OUT_O;
  endproperty
  a_release_idle: assert property (p_release_idle) else $error("chain output driven outside frame");

  property p_read_wiper;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
    execute && cmd == CMD_READ_WIPER |=> shift_q == {`PAD_ZERO, $past(wiper_q)};
  endproperty
  a_read_wiper: assert property (p_read_wiper) else $error("wiper readback not loaded");

  property p_read_memory;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
    execute && cmd == CMD_READ_MEMORY |=> shift_q == {`PAD_ZERO, $past(nv.rd_data)};
  endproperty
  a_read_memory: assert property (p_read_memory) else $error("memory readback not loaded");

  property p_pass_through;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
    execute && cmd == CMD_NOP |=> $stable(shift_q);
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("chained word disturbed");

  property p_shift_in;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
    frame_active && sclk_fall |=> shift_q == {$past(shift_q[`WORD_MSB-1:0]), $past(pin_sync_q[`PIN_DIN])};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");

  property p_tap_decode;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
    $onehot(TAP_SELECT_O) && TAP_SELECT_O[WIPER_CODE_O];
  endproperty
  a_tap_decode: assert property (p_tap_decode) else $error("tap select does not match code");

  property p_preset;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
    state_q == PRESET_RESTORE |-> WIPER_CODE_O == `MIDSCALE ##1
      WIPER_CODE_O == ($past(nv.last_valid) ? $past(nv.last_data) : `MIDSCALE);
  endproperty
  a_preset: assert property (p_preset) else $error("power-on preset wrong");

  property p_soft_reset;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
    execute && cmd == CMD_SOFT_RESET |=>
      WIPER_CODE_O == ($past(nv.last_valid) ? $past(nv.last_data) : `MIDSCALE);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset reload wrong");

endmodule

// file: dv/host_link_model.sv
// Host controller model for the serial port: frames, serial clock and data in.
// Assumes the chain line it samples already includes the pull-up.
module host_link_model (
  output logic sclk_o,
  output logic din_o,
  output logic sync_n_o,
  input wire logic line_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Idle levels
  initial begin
    sclk_o = 1'b0;
    din_o = 1'b1;
    sync_n_o = 1'b1;
  end

  // ==========================================================================
  // One frame of n bits, most significant first, returning what the line carried.
  // Data in changes with the rising serial clock, and both sides sample on the falling edge.
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    #1.3;
    sync_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #32;
      sclk_o = 1'b1;
      din_o = tx[i];
      #32;
      rx = {rx[30:0], line_i};
      sclk_o = 1'b0;
    end
    #32;
    sync_n_o = 1'b1;
    din_o = ~din_o;
    #64;
  endtask
endmodule

// file: dv/testbench.sv
// Testbench for the serial rheostat: a table of single-device frames, then hand-written cases.
// Assumes the host model drives the serial pins and a pull-up sits on the chain line.
`include "digipot_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  int fail_count = 0;
  int num_checks = 0;
  wire sclk;
  wire din;
  wire sync_n;
  logic chain_out;
  logic chain_oe_n;
  logic [`WIPER_W-1:0] wiper_code;
  logic [`TAP_COUNT-1:0] tap_select;
  logic [31:0] rx;
  logic [42:0] rows [16];
  wire chain_line = (chain_oe_n === 1'b0) ? chain_out : 1'b1;

  always #2.5 sys_clk = ~sys_clk;

  host_link_model host (.sclk_o(sclk), .din_o(din), .sync_n_o(sync_n), .line_i(chain_line));

  digipot_serial_daisy_chain #(.TOL_SIGN_INTEGER(10'h00a), .TOL_FRACTION(10'h0b0)) dut (
    .SYS_CLK_I(sys_clk),
    .RESETN_I(resetn),
    .SCLK_I(sclk),
    .DIN_I(din),
    .SYNC_N_I(sync_n),
    .CHAIN_DATA_OUT_O(chain_out),
    .CHAIN_DATA_OE_N_O(chain_oe_n),
    .WIPER_CODE_O(wiper_code),
    .TAP_SELECT_O(tap_select)
  );

  // ==========================================================================
  // Checking and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_wiper(input logic [`WIPER_W-1:0] exp);
    check("wiper", {22'h0, wiper_code}, {22'h0, exp});
    check("tap", {31'h0, tap_select === (`TAP_COUNT'(1) << exp)}, 32'h1);
    check("released", {31'h0, chain_oe_n}, 32'h1);
    check("drive_level", {31'h0, chain_out}, 32'h0);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Reset and frame drivers
  task automatic do_reset;
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check_wiper(10'h200);
    @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    check_wiper(10'h200);
  endtask

  task automatic frame(input logic [31:0] tx, input int n);
    @(posedge sys_clk);
    host.xfer(tx, n, rx);
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (50000) @(posedge sys_clk);
    fail_count++;
    $display("test watchdog expired");
    finish_test();
  end

  // ==========================================================================
  // Main sequence: word sent, readback checked, readback expected, wiper after
  initial begin
    rows = '{
      {16'h1c03, 1'b0, 16'h0000, 10'h200},
      {16'h0500, 1'b1, 16'h1c03, 10'h100},
      {16'h0800, 1'b1, 16'h0500, 10'h100},
      {16'h0c00, 1'b1, 16'h0100, 10'h100},
      {16'h1800, 1'b1, 16'h0c00, 10'h100},
      {16'h0000, 1'b1, 16'h0001, 10'h100},
      {16'h1401, 1'b1, 16'h0000, 10'h100},
      {16'h2000, 1'b1, 16'h0100, 10'h100},
      {16'h1439, 1'b1, 16'h000b, 10'h100},
      {16'h143a, 1'b1, 16'h000a, 10'h100},
      {16'h0480, 1'b1, 16'h00b0, 10'h080},
      {16'h1000, 1'b1, 16'h0480, 10'h100},
      {16'h07ff, 1'b1, 16'h1000, 10'h3ff},
      {16'h0000, 1'b1, 16'h07ff, 10'h3ff},
      {16'h2400, 1'b1, 16'h0000, 10'h3ff},
      {16'h0400, 1'b1, 16'h2400, 10'h000}
    };
    do_reset();
    $display("test reset done");
    foreach (rows[i]) begin
      frame({16'h0, rows[i][42:27]}, 16);
      if (rows[i][26]) check("readback", {16'h0, rx[15:0]}, {16'h0, rows[i][25:10]});
      check_wiper(rows[i][9:0]);
    end
    $display("test table done");
    // Write protection set again, so the next write must be ignored.
    frame(32'h1c00, 16);
    frame(32'h0555, 16);
    check_wiper(10'h000);
    $display("test protect done");
    // Two words in one frame: the near word is a wiper read.
    frame(32'h0123_0800, 32);
    check("chain", rx, 32'h0555_0123);
    frame(32'h0000, 16);
    check("wiper_read", {16'h0, rx[15:0]}, 32'h0000);
    $display("test chain done");
    do_reset();
    // Reset empties the store, so a soft reset must fall back to midscale.
    frame(32'h1c02, 16);
    frame(32'h0444, 16);
    check_wiper(10'h044);
    frame(32'h1000, 16);
    check_wiper(10'h200);
    $display("test second reset done");
    finish_test();
  end
endmodule
